/* pxe_pkg.sv */
// Purpose: Shared types and constants for the quasi-bidirectional port expander
// Assumes: mclk at 200 MHz, serial bus at or below 100 kHz
// Notes:   Notes on behaviour list follows
// Notes on behaviour
// (RULE1) Controller opens each transaction with start
// (RULE2) Address 0100 plus select pins, then direction
// (RULE3) General call address is never acknowledged
// (RULE4) Matching address acknowledged with data low
// (RULE5) Address select pins stable start to stop
// (RULE6) Read: port pins sampled and shifted out
// (RULE7) Write: received byte drives the port pins
// (RULE8) Ack written byte, ignore later bytes
// (RULE9) Pins change only on acknowledged complete byte
// (RULE10) Outputs valid within 4 us of ack
// (RULE11) Controller closes each transaction with stop
// (RULE12) Input pin edge asserts interrupt within 4 us
// (RULE13) Interrupt clears on revert, read or write
// (RULE14) Interrupt clear at ack rising edge
// (RULE15) Changes after clear detected again
// (RULE16) Traffic to other targets leaves interrupt alone
// (RULE17) No registers; byte is the port value
// (RULE18) Strong pull-up on written high, off at fall
// (RULE19) Controller writes pin high before input use
// (RULE20) Serial data valid within 3.4 us of fall
// (RULE21) Serial clock at most 100 kHz
// (RULE22) Bus free and start hold times
// (RULE23) Bit n maps to pin n
// (RULE24) Interrupt output open drain, active low
// (RULE25) Reset idles bus logic, pins all high
package pxe_pkg;

  localparam int          PXE_WIDTH       = 8;
  localparam logic [3:0]  PXE_ADDR_FIXED  = 4'h4;
  localparam logic [3:0]  PXE_BITS_BYTE   = 4'h8;
  localparam logic [3:0]  PXE_LAST_TX_BIT = 4'h7;
  localparam logic [7:0]  PXE_PORT_RST    = 8'hff;

  // Timing figures in ns or ps and their mclk cycle counts
  localparam int PXE_MCLK_PERIOD_PS       = 5000;
  localparam int PXE_PORT_VALID_DELAY_NS  = 4000;
  localparam int PXE_IRQ_ASSERT_DELAY_NS  = 4000;
  localparam int PXE_IRQ_CLEAR_DELAY_NS   = 4000;
  localparam int PXE_SERIAL_OUT_DELAY_PS  = 3400000;
  localparam int PXE_PORT_VALID_CYC = PXE_PORT_VALID_DELAY_NS * 1000 / PXE_MCLK_PERIOD_PS;
  localparam int PXE_IRQ_ASSERT_CYC = PXE_IRQ_ASSERT_DELAY_NS * 1000 / PXE_MCLK_PERIOD_PS;
  localparam int PXE_IRQ_CLEAR_CYC  = PXE_IRQ_CLEAR_DELAY_NS * 1000 / PXE_MCLK_PERIOD_PS;
  localparam int PXE_SERIAL_OUT_CYC = PXE_SERIAL_OUT_DELAY_PS / PXE_MCLK_PERIOD_PS;

  typedef enum logic [2:0] {
    PXE_IDLE,
    PXE_ADDR,
    PXE_ADDR_ACK,
    PXE_WDATA,
    PXE_WACK,
    PXE_RDATA,
    PXE_RACK,
    PXE_IGNORE
  } pxe_state_e;

  // Open-drain pin drive: oe_n low pulls the line to out
  typedef struct packed {
    logic out;
    logic oe_n;
  } pxe_od_s;

  // Port pin drive, one bit per pin
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_n;
  } pxe_port_drv_s;

  // Serial-side state on mclk
  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [1:0][2:0] asel_s;
    pxe_state_e  st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic        sda_low;
    logic        strong_on;
    logic [7:0]  wr_data;
    logic        wr_tgl;
    logic [2:0]  rq_s;
    logic        rq_ack;
    logic [7:0]  pins;
    logic [7:0]  ref_pins;
    logic        irq;
  } pxe_mstate_s;

  // Port-side state on the port clock
  typedef struct packed {
    logic [1:0]      rst_s;
    logic [2:0]      wr_s;
    logic [1:0]      strong_s;
    logic [1:0][7:0] pin_s;
    logic [1:0]      ack_s;
    logic [7:0]      cap;
    logic            rq_tgl;
    logic [7:0]      latch;
    pxe_port_drv_s   drv;
  } pxe_pstate_s;

endpackage

/* pxe_expander.sv */
// Purpose: Serial-bus target driving and sampling an 8-bit quasi-bidirectional port
// Assumes: scl and sda oversampled on mclk; port pins handled on port_clk
// Notes:   Words cross domains by toggle handshake with held data
`timescale 1ns/1ps

module pxe_expander (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   port_clk,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output pxe_pkg::pxe_od_s            sda_drv,
  output pxe_pkg::pxe_od_s            irq_drv,
  input  wire logic [2:0]             target_addr_select_pins,
  input  wire logic [7:0]             quasi_bidir_port_pins_in,
  output pxe_pkg::pxe_port_drv_s      quasi_bidir_port_pins_drv
);
  import pxe_pkg::*;

  pxe_mstate_s m;
  pxe_mstate_s next_m;
  pxe_pstate_s p;
  pxe_pstate_s next_p;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic addr_hit;
  logic rq_new;

  assign scl_rise   = m.scl_s[1] & ~m.scl_s[2];
  assign scl_fall   = ~m.scl_s[1] & m.scl_s[2];
  assign start_cond = m.scl_s[1] & m.scl_s[2] & m.sda_s[2] & ~m.sda_s[1];
  assign stop_cond  = m.scl_s[1] & m.scl_s[2] & ~m.sda_s[2] & m.sda_s[1];
  // Fixed upper nibble excludes the general call address
  assign addr_hit   = (m.sh[7:1] == {PXE_ADDR_FIXED, m.asel_s[1]}) && !m.sh[7]; // see RULE2 RULE3
  assign rq_new     = m.rq_s[1] ^ m.rq_s[2];

  // Serial engine and interrupt on mclk
  always_comb begin
    next_m = m;
    next_m.scl_s     = {m.scl_s[1:0], scl_in};
    next_m.sda_s     = {m.sda_s[1:0], sda_in};
    next_m.asel_s[0] = target_addr_select_pins;
    next_m.asel_s[1] = m.asel_s[0];
    next_m.rq_s      = {m.rq_s[1:0], p.rq_tgl};
    if (rq_new) begin
      next_m.pins   = p.cap;
      next_m.rq_ack = m.rq_s[1];
    end
    if (scl_fall) begin
      next_m.strong_on = 1'b0; // see RULE18
    end
    if (start_cond) begin
      next_m.st      = PXE_ADDR; // see RULE1
      next_m.cnt     = '0;
      next_m.sda_low = 1'b0;
    end else if (stop_cond) begin
      next_m.st      = PXE_IDLE; // see RULE11 RULE9
      next_m.sda_low = 1'b0;
    end else begin
      case (m.st)
        PXE_IDLE: begin
        end
        PXE_ADDR: begin
          if (scl_rise) begin
            next_m.sh  = {m.sh[6:0], m.sda_s[1]};
            next_m.cnt = m.cnt + 4'h1;
          end else if (scl_fall && m.cnt == PXE_BITS_BYTE) begin
            if (addr_hit) begin
              next_m.sda_low = 1'b1; // see RULE4
              next_m.rw      = m.sh[0];
              next_m.st      = PXE_ADDR_ACK;
            end else begin
              next_m.st = PXE_IGNORE; // see RULE16
            end
          end
        end
        PXE_ADDR_ACK: begin
          if (scl_rise && m.rw) begin
            next_m.sh       = m.pins; // see RULE6 RULE23 RULE17
            next_m.ref_pins = m.pins; // see RULE13 RULE14
          end else if (scl_fall) begin
            next_m.cnt = '0;
            if (m.rw) begin
              next_m.st      = PXE_RDATA;
              next_m.sda_low = ~m.sh[7]; // see RULE20
            end else begin
              next_m.st      = PXE_WDATA;
              next_m.sda_low = 1'b0;
            end
          end
        end
        PXE_WDATA: begin
          if (scl_rise) begin
            next_m.sh  = {m.sh[6:0], m.sda_s[1]};
            next_m.cnt = m.cnt + 4'h1;
          end else if (scl_fall && m.cnt == PXE_BITS_BYTE) begin
            next_m.sda_low = 1'b1; // see RULE8
            next_m.st      = PXE_WACK;
          end
        end
        PXE_WACK: begin
          if (scl_rise) begin
            next_m.wr_data   = m.sh; // see RULE7 RULE9 RULE10 RULE23
            next_m.wr_tgl    = ~m.wr_tgl;
            next_m.strong_on = 1'b1; // see RULE18
            next_m.ref_pins  = m.pins; // see RULE13 RULE14
          end else if (scl_fall) begin
            next_m.sda_low = 1'b0;
            next_m.st      = PXE_IGNORE; // see RULE8
          end
        end
        PXE_RDATA: begin
          if (scl_fall) begin
            if (m.cnt == PXE_LAST_TX_BIT) begin
              next_m.sda_low = 1'b0;
              next_m.st      = PXE_RACK;
            end else begin
              next_m.sh      = {m.sh[6:0], 1'b0};
              next_m.sda_low = ~m.sh[6]; // see RULE20
              next_m.cnt     = m.cnt + 4'h1;
            end
          end
        end
        PXE_RACK: begin
          if (scl_rise) begin
            if (m.sda_s[1]) begin
              next_m.st = PXE_IGNORE;
            end else begin
              next_m.sh       = m.pins; // see RULE6
              next_m.ref_pins = m.pins; // see RULE13 RULE14
            end
          end else if (scl_fall) begin
            next_m.st      = PXE_RDATA;
            next_m.cnt     = '0;
            next_m.sda_low = ~m.sh[7];
          end
        end
        PXE_IGNORE: begin
        end
        default: begin
          next_m.st = PXE_IDLE;
        end
      endcase
    end
    // A change in the same cycle as a clear still raises the flag
    next_m.irq = (next_m.pins != next_m.ref_pins); // see RULE12 RULE13 RULE15
    if (rst) begin
      next_m          = '0; // see RULE25
      next_m.scl_s    = {m.scl_s[1:0], scl_in};
      next_m.sda_s    = {m.sda_s[1:0], sda_in};
      next_m.st       = PXE_IDLE;
      next_m.pins     = PXE_PORT_RST;
      next_m.ref_pins = PXE_PORT_RST;
      next_m.wr_data  = PXE_PORT_RST;
    end
  end

  always_ff @(posedge mclk) begin
    m <= next_m;
  end

  // Port latch, pin sampling and pull-up control on port_clk
  always_comb begin
    next_p = p;
    next_p.rst_s     = {p.rst_s[0], rst};
    next_p.wr_s      = {p.wr_s[1:0], m.wr_tgl};
    next_p.strong_s  = {p.strong_s[0], m.strong_on};
    next_p.pin_s[0]  = quasi_bidir_port_pins_in;
    next_p.pin_s[1]  = p.pin_s[0];
    next_p.ack_s     = {p.ack_s[0], m.rq_ack};
    if (p.wr_s[1] ^ p.wr_s[2]) begin
      next_p.latch = m.wr_data; // see RULE7 RULE10
    end
    if (p.ack_s[1] == p.rq_tgl) begin
      next_p.cap    = p.pin_s[1]; // see RULE12
      next_p.rq_tgl = ~p.rq_tgl;
    end
    if (p.rst_s[1]) begin
      next_p.latch  = PXE_PORT_RST; // see RULE25
      next_p.cap    = PXE_PORT_RST;
      next_p.rq_tgl = 1'b0;
    end
    // Low bits drive low; high bits float on the weak source unless boosted
    next_p.drv.level = next_p.latch;
    next_p.drv.oe_n  = next_p.latch & ~{PXE_WIDTH{p.strong_s[1] & ~p.rst_s[1]}}; // see RULE18
  end

  always_ff @(posedge port_clk) begin
    p <= next_p;
  end

  assign sda_drv.out                = 1'b0;
  assign sda_drv.oe_n               = ~m.sda_low; // see RULE4
  assign irq_drv.out                = 1'b0;
  assign irq_drv.oe_n               = ~m.irq; // see RULE24
  assign quasi_bidir_port_pins_drv  = p.drv;

endmodule // pxe_expander

/* pxe_expander_asserts.sv */
// Purpose: Drive and timing checks on the port expander pins
// Assumes: Bound to pxe_expander; bus lines resolved with pull-ups
// Notes:   Helper counters hold cycles since the last event
`timescale 1ns/1ps

module pxe_expander_asserts (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             port_clk,
  input  wire logic             scl_in,
  input  pxe_pkg::pxe_od_s       sda_drv,
  input  pxe_pkg::pxe_od_s       irq_drv,
  input  wire logic [7:0]       quasi_bidir_port_pins_in,
  input  pxe_pkg::pxe_port_drv_s quasi_bidir_port_pins_drv
);
  import pxe_pkg::*;
  logic [10:0] sda_cnt;
  logic [10:0] fall_cnt;
  logic [10:0] pin_cnt;
  always_ff @(posedge mclk) begin
    sda_cnt  <= (rst || !sda_drv.oe_n) ? 11'h000 : sda_cnt + 11'(~&sda_cnt);
    fall_cnt <= (rst || $fell(scl_in)) ? 11'h000 : fall_cnt + 11'(~&fall_cnt);
    pin_cnt  <= (rst || $changed(quasi_bidir_port_pins_in)) ? 11'h000 : pin_cnt + 11'(~&pin_cnt);
  end
  property p_sda_od;
    @(posedge mclk) disable iff (rst) sda_drv.out == 1'b0;
  endproperty
  a_sda_od: assert property (p_sda_od) else $error("sda drive level not low");
  property p_irq_od;
    @(posedge mclk) disable iff (rst) irq_drv.out == 1'b0;
  endproperty
  a_irq_od: assert property (p_irq_od) else $error("irq drive level not low");
  property p_reset_idle;
    @(posedge mclk) disable iff (rst) $fell(rst) |-> sda_drv.oe_n && irq_drv.oe_n
      && quasi_bidir_port_pins_drv.level == PXE_PORT_RST && quasi_bidir_port_pins_drv.oe_n == 8'hff;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("state after reset wrong");
  property p_port_drive;
    @(posedge port_clk) disable iff (rst)
      (~quasi_bidir_port_pins_drv.level & quasi_bidir_port_pins_drv.oe_n) == 8'h00;
  endproperty
  a_port_drive: assert property (p_port_drive) else $error("low pin not driven");
  property p_port_change;
    @(posedge mclk) disable iff (rst) $changed(quasi_bidir_port_pins_drv.level) |-> sda_cnt < 400;
  endproperty
  a_port_change: assert property (p_port_change) else $error("port changed without ack");
  property p_sda_timing;
    @(posedge mclk) disable iff (rst)
      $changed(sda_drv.oe_n) |-> !scl_in && fall_cnt <= PXE_SERIAL_OUT_CYC;
  endproperty
  a_sda_timing: assert property (p_sda_timing) else $error("sda changed late");
  property p_irq_assert;
    @(posedge mclk) disable iff (rst) $changed(quasi_bidir_port_pins_in) && irq_drv.oe_n
      && sda_cnt > 800 |-> ##[1:800] !irq_drv.oe_n;
  endproperty
  a_irq_assert: assert property (p_irq_assert) else $error("irq not raised");
  property p_irq_rel;
    @(posedge mclk) disable iff (rst) $rose(irq_drv.oe_n) |-> pin_cnt < 800 || sda_cnt < 800;
  endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("irq released without cause");
  c_ack: cover property (@(posedge mclk) disable iff (rst) $fell(sda_drv.oe_n));
  c_irq: cover property (@(posedge mclk) disable iff (rst) $fell(irq_drv.oe_n));
  c_port: cover property (@(posedge mclk) disable iff (rst) $changed(quasi_bidir_port_pins_drv.level));
endmodule // pxe_expander_asserts

bind pxe_expander pxe_expander_asserts pxe_expander_asserts_inst (
  .mclk, .rst, .port_clk, .scl_in, .sda_drv, .irq_drv,
  .quasi_bidir_port_pins_in, .quasi_bidir_port_pins_drv);

/* pxe_i2c_ctl.sv */
// Purpose: Serial bus controller model driving scl and sda
// Assumes: Open-drain lines with pull-ups resolved by the bench
// Notes:   Bus timing scaled down to keep the run short
`timescale 1ns/1ps

module pxe_i2c_ctl (
  input  wire logic mclk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_o
);
  // Half period in mclk cycles, scaled down from the bus figures
  int hp = 120;
  initial begin
    scl   = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic start();
    sda_o = 1'b1;
    tick(20);
    scl = 1'b1;
    tick(hp);
    sda_o = 1'b0;
    tick(hp);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(20);
    sda_o = 1'b0;
    tick(hp);
    scl = 1'b1;
    tick(hp);
    sda_o = 1'b1;
    tick(hp);
  endtask
  task automatic bit_io(input logic b, output logic r);
    tick(20);
    sda_o = b;
    tick(hp);
    scl = 1'b1;
    tick(hp);
    r   = sda_in;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ab, a);
  endtask
endmodule // pxe_i2c_ctl

/* tb_top.sv */
// Purpose: Self-checking bench for the port expander
// Assumes: Serial lines and port pins resolved here with pull-ups
// Notes:   Port side runs on a 12 ns clock
`timescale 1ns/1ps

module tb_top;
  import pxe_pkg::*;
  logic          mclk     = 1'b0;
  logic          port_clk = 1'b0;
  logic          rst      = 1'b1;
  logic [2:0]    asel     = 3'h0;
  logic [7:0]    ext      = 8'hff;
  logic [7:0]    q;
  logic          a;
  logic          scl;
  logic          sda_o;
  int            n_fail, num_checks, cyc;
  pxe_od_s       sda_drv, irq_drv;
  pxe_port_drv_s drv;
  wire           sda   = sda_o & (sda_drv.oe_n | sda_drv.out);
  wire           irq_n = irq_drv.oe_n | irq_drv.out;
  wire [7:0]     pins  = (drv.oe_n & ext) | (~drv.oe_n & drv.level);
  always #2.5 mclk = ~mclk;
  always #6 port_clk = ~port_clk;
  pxe_i2c_ctl pxe_i2c_ctl_inst (.mclk(mclk), .sda_in(sda), .scl(scl), .sda_o(sda_o));
  pxe_expander pxe_expander_inst (.mclk(mclk), .rst(rst), .port_clk(port_clk), .scl_in(scl),
    .sda_in(sda), .sda_drv(sda_drv), .irq_drv(irq_drv), .target_addr_select_pins(asel),
    .quasi_bidir_port_pins_in(pins), .quasi_bidir_port_pins_drv(drv));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_irq(input logic e);
    for (int i = 0; i < 800 && irq_n !== e; i++) pxe_i2c_ctl_inst.tick(1);
    chk("irq", {7'h00, e}, {7'h00, irq_n});
  endtask
  task automatic s_write(input logic [2:0] sel, input logic [7:0] d);
    asel = sel;
    pxe_i2c_ctl_inst.start();
    pxe_i2c_ctl_inst.xfer({PXE_ADDR_FIXED, sel, 1'b0}, 1'b1, q, a);
    chk("addr_ack", 8'h00, {7'h00, a});
    pxe_i2c_ctl_inst.xfer(d, 1'b1, q, a);
    chk("data_ack", 8'h00, {7'h00, a});
    chk("port", d, pins);
    pxe_i2c_ctl_inst.xfer(~d, 1'b1, q, a);
    chk("extra_nack", 8'h01, {7'h00, a});
    pxe_i2c_ctl_inst.stop();
    chk("drive", d, drv.oe_n);
  endtask
  task automatic s_refuse(input logic [7:0] ad, input logic [7:0] exp);
    pxe_i2c_ctl_inst.start();
    pxe_i2c_ctl_inst.xfer(ad, 1'b1, q, a);
    chk("nack", 8'h01, {7'h00, a});
    pxe_i2c_ctl_inst.stop();
    chk("port_kept", exp, pins);
  endtask
  task automatic s_partial(input logic [7:0] exp);
    pxe_i2c_ctl_inst.start();
    pxe_i2c_ctl_inst.xfer({PXE_ADDR_FIXED, asel, 1'b0}, 1'b1, q, a);
    for (int i = 0; i < 4; i++) pxe_i2c_ctl_inst.bit_io(1'b0, a);
    pxe_i2c_ctl_inst.stop();
    chk("partial", exp, pins);
  endtask
  task automatic s_read(input logic [7:0] exp);
    pxe_i2c_ctl_inst.start();
    pxe_i2c_ctl_inst.xfer({PXE_ADDR_FIXED, asel, 1'b1}, 1'b1, q, a);
    chk("rd_ack", 8'h00, {7'h00, a});
    chk("irq_clr", 8'h01, {7'h00, irq_n});
    pxe_i2c_ctl_inst.xfer(8'hff, 1'b1, q, a);
    chk("rd_data", exp, q);
    pxe_i2c_ctl_inst.stop();
  endtask
  task automatic s_irq();
    s_read(8'hff);
    ext = 8'h3c;
    wait_irq(1'b0);
    s_refuse(8'h49, 8'h3c);
    chk("irq_other", 8'h00, {7'h00, irq_n});
    s_read(8'h3c);
    ext = 8'h38;
    wait_irq(1'b0);
    ext = 8'h3c;
    wait_irq(1'b1);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    pxe_i2c_ctl_inst.tick(200);
    chk("reset_port", PXE_PORT_RST, pins);
    s_write(3'h0, 8'h5a);
    s_refuse(8'h42, 8'h5a);
    pxe_i2c_ctl_inst.hp = 600;
    s_refuse(8'h00, 8'h5a);
    pxe_i2c_ctl_inst.hp = 120;
    s_partial(8'h5a);
    s_write(3'h7, 8'hff);
    s_irq();
    report_and_stop();
  end
endmodule // tb_top
